// ===== logic/glitchless_clock_switchover_mux.sv
/*
 * Two-input clock selector that switches without runt pulses, freezes the
 * output on a dead input and can be bypassed to a plain multiplexer.
 * Assumes both input clocks are sampled by clk_sys and run well below 62 MHz.
 */
// Function
// RQ1: input clock ratio at most 1.5:1
// RQ2: follow current, hold low, then follow target
// RQ3: switchover done within 17 clock cycles
// RQ4: capacitor tied high gives plain multiplexer
// RQ5: both inputs handled identically
// RQ6: dead selected input freezes output level
// RQ7: stuck high: hold high, low, then follow
// RQ8: extended cycle halves exceed half period
// RQ9: stuck low: hold low, then follow
// RQ10: undetermined failure uses last valid level
// RQ11: dead input gives stable output
// RQ12: degrading toggling input not protected
// RQ13: stage pulse counts may vary
// RQ14: power-up reset holds logic in known state
// RQ15: select low first input, high second
// RQ16: output low during power-up reset
`timescale 1ns/100ps
module glitchless_clock_switchover_mux
	import clk_switch_pkg::*;
#(
	parameter int PorCycles = POR_CYCLES
) (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic clockInputA,
	input  wire logic clockInputB,
	input  wire logic selectB,
	input  wire logic delayCapTiedHigh,
	output logic      clkOut,
	output logic      activeB,
	output logic      switching
);
	localparam int PW = $clog2(PorCycles + 1);
	localparam logic [PW-1:0] POR_LAST = PW'(PorCycles - 1);
	localparam logic [PW-1:0] POR_ONE  = PW'(1);

	if (PorCycles < 1) begin : gBadPor
		$error("PorCycles must be at least 1");
	end

	// ****************************************
	// input monitors
	// ****************************************
	clk_mon_if monBus[2] ();
	logic [1:0] pinClk;
	logic [1:0] lvl;
	logic [1:0] rise;
	logic [1:0] fall;
	logic [1:0] dead;

	assign pinClk = {clockInputB, clockInputA};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gMon
			input_monitor #(
				.DeadCycles (DEAD_CYCLES)
			) uMon (
				.clk_sys (clk_sys),
				.rst_n   (rst_n),
				.clkIn   (pinClk[g]),
				.mon     (monBus[g])
			); // see RQ5
			assign lvl[g]  = monBus[g].level;
			assign rise[g] = monBus[g].rise;
			assign fall[g] = monBus[g].fall;
			assign dead[g] = monBus[g].dead;
		end
	endgenerate

	// ****************************************
	// switch state
	// ****************************************
	typedef struct packed {
		logic          selS1;
		logic          selS2;
		logic          capS1;
		logic          capS2;
		logic          porDone;
		logic [PW-1:0] porCnt;
		sw_state_t     state;
		logic          curSel;
		logic [1:0]    cnt;
		logic          outLvl;
		logic [4:0]    swCnt;
	} sw_reg_t;

	sw_reg_t s_q, s_d;

	logic curLvl;
	logic curDead;
	logic tgt;
	logic selChange;

	assign curLvl    = lvl[s_q.curSel];
	assign curDead   = dead[s_q.curSel];
	assign tgt       = ~s_q.curSel;
	assign selChange = s_q.selS2 != s_q.curSel; // see RQ15

	always_comb begin
		s_d       = s_q;
		// select and strap are asynchronous pins; two stages each
		s_d.selS1 = selectB;
		s_d.selS2 = s_q.selS1; // sync adds an edge of slack, see RQ13
		s_d.capS1 = delayCapTiedHigh;
		s_d.capS2 = s_q.capS1;
		if (!s_q.porDone) begin
			s_d.outLvl = 1'b0; // see RQ16
			s_d.porCnt = s_q.porCnt + POR_ONE;
			if (s_q.porCnt == POR_LAST) begin
				s_d.porDone = 1'b1; // see RQ14
			end
		end else begin
			unique case (s_q.state)
				ST_FOLLOW: begin
					// freeze on a dead input rather than pass its noise
					s_d.outLvl = curDead ? s_q.outLvl : curLvl; // see RQ6 RQ11
					if (selChange) begin
						s_d.cnt = '0;
						if (s_q.capS2) begin
							s_d.curSel = s_q.selS2; // see RQ4
							s_d.outLvl = lvl[s_q.selS2];
						end else if (curDead) begin
							s_d.state = curLvl ? ST_STUCK_HI : ST_QUIET; // see RQ10
						end else begin
							s_d.state = ST_DRAIN; // see RQ2
						end
					end
				end
				ST_DRAIN: begin
					s_d.outLvl = curLvl;
					if (fall[s_q.curSel] || curDead) begin
						s_d.state = (curDead && curLvl) ? ST_STUCK_HI : ST_QUIET;
					end
				end
				ST_STUCK_HI: begin
					// high spans whole target periods, so both halves stay long
					s_d.outLvl = 1'b1; // see RQ7 RQ8
					if (rise[tgt]) begin
						if (s_q.cnt == HIGH_PULSES - CNT_STEP) begin
							s_d.outLvl = 1'b0;
							s_d.cnt    = '0;
							s_d.state  = ST_QUIET;
						end else begin
							s_d.cnt = s_q.cnt + CNT_STEP;
						end
					end
				end
				ST_QUIET: begin
					s_d.outLvl = 1'b0; // see RQ2 RQ9
					// hand over only right after a target fall, so no runt
					if (fall[tgt]) begin
						if (s_q.cnt == QUIET_EDGES - CNT_STEP) begin
							s_d.curSel = tgt;
							s_d.outLvl = lvl[tgt];
							s_d.state  = ST_FOLLOW;
						end else begin
							s_d.cnt = s_q.cnt + CNT_STEP;
						end
					end
				end
			endcase
		end
		// target rising edges spent in the switchover
		if (s_q.state == ST_FOLLOW) begin
			s_d.swCnt = '0;
		end else if (rise[tgt] && s_q.swCnt != SWITCH_MAX) begin
			s_d.swCnt = s_q.swCnt + SW_STEP; // see RQ3
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign clkOut    = s_q.outLvl;
	assign activeB   = s_q.curSel;
	assign switching = s_q.state != ST_FOLLOW;

	// ****************************************
	// checks
	// ****************************************
	AST_POR_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ16
		!s_q.porDone && $past(!s_q.porDone) |-> !clkOut)
		else $error("output not low during power-up hold");

	AST_BYPASS: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ4
		s_q.porDone && s_q.state == ST_FOLLOW && selChange && s_q.capS2
		|=> activeB == $past(s_q.selS2) && clkOut == $past(lvl[s_q.selS2]))
		else $error("bypass did not switch at once");

	AST_QUIET_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ2
		s_q.state == ST_QUIET && $past(s_q.state) == ST_QUIET |-> !clkOut)
		else $error("output not low in quiet stage");

	AST_HIGH_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ7
		s_q.state == ST_STUCK_HI && $past(s_q.state) == ST_STUCK_HI |-> clkOut)
		else $error("output not high in stuck-high stage");

	AST_FREEZE: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ6
		s_q.porDone && s_q.state == ST_FOLLOW && curDead && !selChange
		|=> $stable(clkOut))
		else $error("output moved on a dead input");

	AST_FOLLOW: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ5
		s_q.porDone && s_q.state == ST_FOLLOW && !curDead && !selChange
		|=> clkOut == $past(curLvl))
		else $error("output not following selected input");

	AST_BOUND: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ3
		s_q.state != ST_FOLLOW |-> s_q.swCnt < SWITCH_MAX)
		else $error("switchover longer than its bound");

	AST_STUCK_PICK: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ10
		s_q.porDone && s_q.state == ST_FOLLOW && selChange && !s_q.capS2 && curDead
		|=> s_q.state == ($past(curLvl) ? ST_STUCK_HI : ST_QUIET))
		else $error("wrong stage after failed input");

endmodule // glitchless_clock_switchover_mux

// ===== logic/clk_switch_pkg.sv
/*
 * Constants shared by the glitchless clock switchover: timing figures, stage
 * pulse counts and the switchover state encoding.
 * Assumes a single system clock of 125 MHz that oversamples both input clocks.
 */
package clk_switch_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 8;
	// no edge for this long marks an input as dead
	localparam int DEAD_TIME_NS  = 2000;
	localparam int DEAD_CYCLES   = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// power-up hold, stands in for the capacitor delay
	localparam int POR_TIME_US   = 12000;
	localparam int POR_CYCLES    = (POR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************
	// stage counts, in target-clock edges
	// ****************************************
	localparam logic [1:0] HIGH_PULSES = 2'h2;
	localparam logic [1:0] QUIET_EDGES = 2'h2;
	localparam logic [1:0] CNT_STEP    = 2'h1;
	localparam logic [4:0] SWITCH_MAX  = 5'h11;
	localparam logic [4:0] SW_STEP     = 5'h01;

	typedef enum logic [1:0] {
		ST_FOLLOW    = 2'b00,
		ST_DRAIN     = 2'b01,
		ST_STUCK_HI  = 2'b10,
		ST_QUIET     = 2'b11
	} sw_state_t;

endpackage

// ===== logic/clk_mon_if.sv
/*
 * Interface carrying one input monitor's view of its clock to the switch core.
 * Assumes the monitor and the core share clk_sys.
 */
`timescale 1ns/100ps
interface clk_mon_if;
	logic level;
	logic rise;
	logic fall;
	logic dead;

	modport mon (output level, output rise, output fall, output dead);
	modport ctl (input level, input rise, input fall, input dead);
endinterface

// ===== logic/input_monitor.sv
/*
 * Samples one asynchronous input clock, reports its level, edges and whether
 * it has stopped toggling.
 * Assumes the input clock is well below half of clk_sys.
 */
`timescale 1ns/100ps
module input_monitor
	import clk_switch_pkg::*;
#(
	parameter int DeadCycles = DEAD_CYCLES
) (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic clkIn,
	clk_mon_if.mon    mon
);
	localparam int IW = $clog2(DeadCycles + 1);
	localparam logic [IW-1:0] IDLE_MAX = IW'(DeadCycles);
	localparam logic [IW-1:0] IDLE_ONE = IW'(1);

	// below this a slow clock cannot be told from a dead one
	if (DeadCycles < 4) begin : gBadDead
		$error("DeadCycles too small");
	end

	typedef struct packed {
		logic          s1;
		logic          s2;
		logic          lvl;
		logic          rise;
		logic          fall;
		logic [IW-1:0] idle;
		logic          dead;
	} mon_state_t;

	mon_state_t s_q, s_d;

	always_comb begin
		s_d      = s_q;
		s_d.s1   = clkIn;
		s_d.s2   = s_q.s1;
		s_d.lvl  = s_q.s2; // weak but toggling input passes as is, see RQ12
		s_d.rise = s_q.s2 & ~s_q.lvl;
		s_d.fall = ~s_q.s2 & s_q.lvl;
		// level stays frozen at its last valid value while dead
		if (s_q.s2 != s_q.lvl) begin
			s_d.idle = '0;
		end else if (s_q.idle != IDLE_MAX) begin
			s_d.idle = s_q.idle + IDLE_ONE;
		end
		s_d.dead = (s_d.idle == IDLE_MAX);
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign mon.level = s_q.lvl;
	assign mon.rise  = s_q.rise;
	assign mon.fall  = s_q.fall;
	assign mon.dead  = s_q.dead;

endmodule // input_monitor

// ===== testbench/clock_source_pair.sv
/*
 * Two clock sources for the switchover bench; each can stop at its level.
 * Assumes the bench keeps their frequency ratio legal.
 */
`timescale 1ns/100ps
module clock_source_pair #(
	parameter int HalfANs = 41,
	parameter int HalfBNs = 53
) (
	input  wire logic runA,
	input  wire logic runB,
	output logic      clkA,
	output logic      clkB
);
	// ****************************************
	// sources
	// ****************************************
	// 82 ns against 106 ns stays under 1.5:1
	logic phA = 1'b0;
	logic phB = 1'b0;
	always #(HalfANs) phA = ~phA;
	always #(HalfBNs) phB = ~phB;
	// a stopped source holds its level, never a short pulse
	// one process per output keeps a single driver on each
	initial begin
		clkA = 1'b0;
		forever begin
			@(phA);
			if (runA) clkA = phA;
		end
	end
	initial begin
		clkB = 1'b0;
		forever begin
			@(phB);
			if (runB) clkB = phB;
		end
	end
endmodule // clock_source_pair

// ===== testbench/test_glitchless_clock_switchover_mux.sv
/*
 * Self-checking bench for the glitchless clock switchover.
 * Assumes clock_source_pair drives both input clocks.
 */
`timescale 1ns/100ps
module test_glitchless_clock_switchover_mux;
	localparam int Por = 20;
	typedef struct packed {logic sel; logic strap; logic expB;} row_t;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic selectB = 1'b0;
	logic delayCapTiedHigh = 1'b0;
	logic runA = 1'b1;
	logic runB = 1'b1;
	logic clockInputA, clockInputB, clkOut, activeB, switching;
	int miscompares = 0;
	int n_compared = 0;
	realtime tLast = 0;
	realtime minW = 1000;
	bit mon = 0;
	row_t rows[4] = '{'{1'h1, 1'h0, 1'h1}, '{1'h0, 1'h0, 1'h0},
		'{1'h1, 1'h1, 1'h1}, '{1'h0, 1'h1, 1'h0}};

	// ****************************************
	// harness
	// ****************************************
	always #4 clk_sys = ~clk_sys;
	clock_source_pair src (.runA(runA), .runB(runB), .clkA(clockInputA), .clkB(clockInputB));
	glitchless_clock_switchover_mux #(.PorCycles(Por)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
		.clockInputA(clockInputA), .clockInputB(clockInputB), .selectB(selectB),
		.delayCapTiedHigh(delayCapTiedHigh), .clkOut(clkOut), .activeB(activeB),
		.switching(switching));

	// shortest output pulse while suppression is on
	always @(clkOut) begin
		if (mon && ($realtime - tLast) < minW) minW = $realtime - tLast;
		tLast = $realtime;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic waitOut(input logic v);
		int i;
		i = 0;
		while (clkOut !== v && i < 300) begin
			tick(1);
			i++;
		end
	endtask

	task automatic settle();
		int i;
		i = 0;
		tick(4);
		while (switching !== 1'b0 && i < 232) begin
			tick(1);
			i++;
		end
		check("switchDone", switching, 1'h0);
	endtask

	// rising edges of output and chosen pin must match within one
	task automatic follows(input string what, input logic useB);
		int nOut, nIn;
		logic pOut, pIn, pin;
		nOut = 0;
		nIn = 0;
		pOut = clkOut;
		pIn = useB ? clockInputB : clockInputA;
		repeat (150) begin
			tick(1);
			pin = useB ? clockInputB : clockInputA;
			nOut += int'(clkOut & ~pOut);
			nIn += int'(pin & ~pIn);
			pOut = clkOut;
			pIn = pin;
		end
		check(what, nIn > 0 && nOut >= nIn - 1 && nOut <= nIn + 1, 1'h1);
	endtask

	task automatic conclude();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	initial begin : watchdog
		repeat (40000) @(posedge clk_sys);
		miscompares++;
		conclude();
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin : main
		realtime t0;
		tick(4);
		rst_n = 1'b1;
		tick(Por + 4);
		mon = 1;
		follows("followA", 1'b0);
		$display("follow A done");
		foreach (rows[i]) begin
			selectB = rows[i].sel;
			delayCapTiedHigh = rows[i].strap;
			mon = !rows[i].strap;
			if (rows[i].strap) tick(4);
			else settle();
			check("activeB", activeB, rows[i].expB);
			follows("followRow", rows[i].expB);
			$display("row %0d done", i);
		end
		delayCapTiedHigh = 1'b0;
		mon = 1;
		tick(4);
		wait (clockInputA === 1'b1);
		runA = 1'b0;
		tick(300);
		check("frozenHigh", clkOut, 1'h1);
		selectB = 1'b1;
		waitOut(1'b0);
		t0 = $realtime;
		waitOut(1'b1);
		check("extLow", ($realtime - t0) > 53, 1'h1);
		settle();
		check("activeB", activeB, 1'h1);
		follows("followB", 1'b1);
		$display("stuck high done");
		runA = 1'b1;
		wait (clockInputB === 1'b0);
		runB = 1'b0;
		tick(300);
		check("frozenLow", clkOut, 1'h0);
		selectB = 1'b0;
		settle();
		check("activeB", activeB, 1'h0);
		follows("followA", 1'b0);
		runB = 1'b1;
		check("minPulse", minW >= 32, 1'h1);
		$display("stuck low done");
		rst_n = 1'b0;
		tick(2);
		check("rstOut", {clkOut, activeB, switching}, 3'h0);
		rst_n = 1'b1;
		tick(Por - 4);
		check("porOut", clkOut, 1'h0);
		tick(8);
		follows("porFollow", 1'b0);
		$display("reset done");
		conclude();
	end
endmodule // test_glitchless_clock_switchover_mux
